//--- src/line_state_pkg.sv
package line_state_pkg;

	// register byte addresses
	localparam logic [7:0] line_state_status_addr = 8'h10;
	localparam logic [7:0] event_status_addr = 8'h20;
	localparam logic [7:0] event_mask_addr = 8'h24;

	// line state status field positions
	localparam int signal_lost_bit = 10;
	localparam int prev_field_lsb = 8;
	localparam int cur_field_lsb = 5;
	localparam logic [15:0] line_state_status_reset = 16'h0000;

	// current line condition codes
	localparam logic [2:0] code_noise = 3'h0;
	localparam logic [2:0] code_active = 3'h1;
	localparam logic [2:0] code_undefined = 3'h2;
	localparam logic [2:0] code_short_idle = 3'h3;
	localparam logic [2:0] code_quiet = 3'h4;
	localparam logic [2:0] code_master = 3'h5;
	localparam logic [2:0] code_halt = 3'h6;
	localparam logic [2:0] code_long_idle = 3'h7;

	// previous line condition codes
	localparam logic [1:0] prev_quiet = 2'h0;
	localparam logic [1:0] prev_master = 2'h1;
	localparam logic [1:0] prev_halt = 2'h2;
	localparam logic [1:0] prev_long_idle = 2'h3;

	// symbol pair counts (count is pairs seen minus one)
	localparam logic [2:0] pairs_full = 3'h7;
	localparam logic [2:0] pairs_short_idle = 3'h1;

	// event status bits
	localparam int ev_line_change = 0;
	localparam int ev_prev_update = 1;
	localparam int ev_signal_lost = 2;
	localparam int ev_signal_back = 3;
	localparam int ev_width = 4;

endpackage : line_state_pkg

//--- src/symbol_pair_counter.sv
`timescale 1ns/1ps
`default_nettype none

// counts consecutive like symbol pairs, saturating at the top
module symbol_pair_counter #(
	parameter int CNT_W = 3,
	parameter int KIND_W = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pair_valid,
	input wire logic [KIND_W-1:0] pair_kind,
	output logic [KIND_W-1:0] run_kind,
	output logic [CNT_W-1:0] run_count,
	output logic run_update
);

	initial begin
		if (CNT_W < 3 || KIND_W < 3) begin
			$error("symbol_pair_counter: widths below 3 cannot hold the codes");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// a new kind restarts the run; saturation keeps a long run stable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_kind <= '0;
			run_count <= '0;
		end else if (pair_valid) begin
			if (pair_kind != run_kind) begin
				run_kind <= pair_kind;
				run_count <= '0;
			end else if (run_count != {CNT_W{1'b1}}) begin
				run_count <= run_count + 1'b1;
			end
		end
	end

	// flags that run_kind and run_count were just refreshed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_update <= 1'b0;
		end else begin
			run_update <= pair_valid;
		end
	end

endmodule : symbol_pair_counter

`default_nettype wire

//--- src/line_state_status_reg.sv
// Function
// - the read-only line state status register sits at address 0x10.
// - bit 10 reads as the inverse of the signal present input.
// - bits 9:8 capture the state left when leaving quiet, master, halt or long idle.
// - leaving any other line state leaves bits 9:8 unchanged.
// - bits 9:8 code quiet 00, master 01, halt 10, long idle 11.
// - long idle is reached only after 16 idle symbols.
// - bits 7:5 hold the most recently recognised line state.
// - noise codes as 000 and active as 001 in bits 7:5.
// - other codes are 010 undefined, 011 short idle, 100 quiet, 101 master, 110 halt, 111 long idle.
// - a state is recognised after eight like symbol pairs, short idle after two idle pairs.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module line_state_status_reg #(
	parameter int CNT_W = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signal_present_input,
	input wire logic pair_valid,
	input wire logic [2:0] pair_class,
	output logic irq
);

	initial begin
		if (CNT_W != 3) begin
			$error("line_state_status_reg: pair counter must be 3 bits");
		end
	end

	// one-hot states of the line condition machine
	typedef enum logic [6:0] {
		st_noise = 7'b0000001,
		st_active = 7'b0000010,
		st_short_idle = 7'b0000100,
		st_quiet = 7'b0001000,
		st_master = 7'b0010000,
		st_halt = 7'b0100000,
		st_long_idle = 7'b1000000
	} line_condition_e;

	line_condition_e line_condition_machine;
	line_condition_e next_line_condition;
	logic [2:0] current_line_condition;
	logic [2:0] next_code;
	logic [1:0] previous_line_condition;
	logic signal_meta;
	logic signal_sync;
	logic signal_sync_d;
	logic signal_lost;
	logic [2:0] run_kind;
	logic [2:0] run_count;
	logic run_update;
	logic state_change;
	logic leave_sticky;
	logic [line_state_pkg::ev_width-1:0] event_status;
	logic [line_state_pkg::ev_width-1:0] event_mask;
	logic [line_state_pkg::ev_width-1:0] event_set;
	logic setup_phase;
	logic write_take;
	logic mapped;
	logic [15:0] line_state_word;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser; only the second stage feeds logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			signal_meta <= 1'b0;
			signal_sync <= 1'b0;
		end else begin
			signal_meta <= signal_present_input;
			signal_sync <= signal_meta;
		end
	end

	// delayed copy for edge events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			signal_sync_d <= 1'b0;
		end else begin
			signal_sync_d <= signal_sync;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			signal_lost <= 1'b1;
		end else begin
			signal_lost <= ~signal_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// consecutive like pair counting
	symbol_pair_counter #(
		.CNT_W(CNT_W),
		.KIND_W(3)
	) pair_counter (
		.pclk(pclk),
		.presetn(presetn),
		.pair_valid(pair_valid),
		.pair_kind(pair_class),
		.run_kind(run_kind),
		.run_count(run_count),
		.run_update(run_update)
	);

	////////////////////////////////////////////////////////////////////////
	// recognition of a new line state from the current run
	always_comb begin
		next_line_condition = line_condition_machine;
		if (run_update) begin
			// eight like pairs, two for short idle
			if (run_count == line_state_pkg::pairs_full) begin
				unique case (run_kind)
					line_state_pkg::code_noise: next_line_condition = st_noise;
					line_state_pkg::code_active: next_line_condition = st_active;
					// eight idle pairs are sixteen idle symbols
					line_state_pkg::code_short_idle: next_line_condition = st_long_idle;
					line_state_pkg::code_quiet: next_line_condition = st_quiet;
					line_state_pkg::code_master: next_line_condition = st_master;
					line_state_pkg::code_halt: next_line_condition = st_halt;
					default: next_line_condition = line_condition_machine;
				endcase
			end else if (run_kind == line_state_pkg::code_short_idle
					&& run_count >= line_state_pkg::pairs_short_idle
					&& line_condition_machine != st_long_idle) begin
				next_line_condition = st_short_idle;
			end
		end
	end

	always_comb begin
		unique case (next_line_condition)
			st_noise: next_code = line_state_pkg::code_noise;
			st_active: next_code = line_state_pkg::code_active;
			st_short_idle: next_code = line_state_pkg::code_short_idle;
			st_quiet: next_code = line_state_pkg::code_quiet;
			st_master: next_code = line_state_pkg::code_master;
			st_halt: next_code = line_state_pkg::code_halt;
			st_long_idle: next_code = line_state_pkg::code_long_idle;
			default: next_code = line_state_pkg::code_undefined;
		endcase
	end

	assign state_change = (next_line_condition != line_condition_machine);

	// sticky origins are the four states with a previous code
	assign leave_sticky = (line_condition_machine == st_quiet)
		|| (line_condition_machine == st_master)
		|| (line_condition_machine == st_halt)
		|| (line_condition_machine == st_long_idle);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_condition_machine <= st_noise;
			current_line_condition <= line_state_pkg::code_noise;
		end else begin
			line_condition_machine <= next_line_condition;
			current_line_condition <= next_code;
		end
	end

	// low two code bits give the previous code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			previous_line_condition <= line_state_pkg::prev_quiet;
		end else if (state_change && leave_sticky) begin
			previous_line_condition <= current_line_condition[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reserved bits zero
	always_comb begin
		line_state_word = line_state_pkg::line_state_status_reset;
		line_state_word[line_state_pkg::signal_lost_bit] = signal_lost;
		line_state_word[line_state_pkg::prev_field_lsb +: 2] = previous_line_condition;
		line_state_word[line_state_pkg::cur_field_lsb +: 3] = current_line_condition;
	end

	// apb decode; the answer is prepared in the setup cycle
	assign setup_phase = psel && !penable;
	assign mapped = (paddr == line_state_pkg::line_state_status_addr)
		|| (paddr == line_state_pkg::event_status_addr)
		|| (paddr == line_state_pkg::event_mask_addr);
	assign write_take = psel && penable && pready && pwrite && pstrb[0];

	// zero wait state: pready rises for the single access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_phase;
			// status word is read-only, writes to it fail
			pslverr <= setup_phase && (!mapped
				|| (pwrite && paddr == line_state_pkg::line_state_status_addr));
		end
	end

	// read data is a plain copy, nothing clears on read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup_phase && !pwrite) begin
			unique case (paddr)
				line_state_pkg::line_state_status_addr: prdata <= {16'h0000, line_state_word};
				line_state_pkg::event_status_addr: prdata <= {28'h0000000, event_status};
				line_state_pkg::event_mask_addr: prdata <= {28'h0000000, event_mask};
				default: prdata <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt mask, written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_mask <= '0;
		end else if (write_take && paddr == line_state_pkg::event_mask_addr) begin
			event_mask <= pwdata[line_state_pkg::ev_width-1:0];
		end
	end

	// events raised by the line machine and the signal pin
	always_comb begin
		event_set = '0;
		event_set[line_state_pkg::ev_line_change] = state_change;
		event_set[line_state_pkg::ev_prev_update] = state_change && leave_sticky;
		event_set[line_state_pkg::ev_signal_lost] = signal_sync_d && !signal_sync;
		event_set[line_state_pkg::ev_signal_back] = !signal_sync_d && signal_sync;
	end

	// write one to clear; a set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_status <= '0;
		end else if (write_take && paddr == line_state_pkg::event_status_addr) begin
			event_status <= (event_status & ~pwdata[line_state_pkg::ev_width-1:0]) | event_set;
		end else begin
			event_status <= event_status | event_set;
		end
	end

	// level interrupt, one cycle behind the status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(event_status & event_mask);
		end
	end

endmodule : line_state_status_reg

`default_nettype wire

//--- test/line_state_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// port level checks of the bus and the status word
module line_state_status_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic signal_present_input,
	input wire logic pair_valid,
	input wire logic [2:0] pair_class,
	input wire logic irq
);
	logic pin_q;
	logic [2:0] pin_age;
	logic setup;
	logic rd_st;
	// pin age, so the synchroniser delay never trips the check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= 1'b0;
			pin_age <= 3'h0;
		end else begin
			pin_q <= signal_present_input;
			if (signal_present_input != pin_q) begin
				pin_age <= 3'h0;
			end else if (pin_age != 3'h7) begin
				pin_age <= pin_age + 3'h1;
			end
		end
	end
	assign setup = psel && !penable;
	assign rd_st = pready && !pwrite && paddr == line_state_pkg::line_state_status_addr;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_after_setup: assert property (setup |=> pready && penable)
		else $error("no ready after setup");
	chk_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	chk_ro_write_err: assert property (setup && pwrite && paddr == 8'h10 |=> pslverr)
		else $error("write to status not refused");
	chk_unmapped_err: assert property (setup && !(paddr inside {8'h10, 8'h20, 8'h24})
		|=> pslverr)
		else $error("unmapped access not refused");
	chk_status_read_ok: assert property (setup && !pwrite && paddr == 8'h10 |=> !pslverr)
		else $error("status read refused");
	chk_reserved_zero: assert property (rd_st |-> prdata[31:11] == 21'h0)
		else $error("reserved bits not zero");
	chk_lost_tracks_pin: assert property (rd_st && pin_age > 3'h4
		|-> prdata[10] == !signal_present_input)
		else $error("signal lost bit wrong");
	chk_no_undef_code: assert property (rd_st |-> prdata[7:5] != 3'h2)
		else $error("undefined line code shown");
endmodule : line_state_status_sva
bind line_state_status_reg line_state_status_sva line_state_status_sva_i (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
	.signal_present_input, .pair_valid, .pair_class, .irq);
`default_nettype wire

//--- test/line_state_status_reg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module line_state_status_reg_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, irq, err, pin = 1'b1, pair_valid = 1'b0;
	logic [2:0] pair_class = 3'h0;
	int n_fail = 0, total_checks = 0;
	line_state_status_reg line_state_status_reg_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .signal_present_input(pin),
		.pair_valid, .pair_class, .irq);
	always #10 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		// a transfer that never completes counts as a mismatch
		if (pready !== 1'b1) n_fail++;
		rd = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	// n back to back pairs of one class, then let the state land
	task pairs(input logic [2:0] c, input int n);
		repeat (n) begin @(posedge pclk); pair_valid <= 1'b1; pair_class <= c; end
		@(posedge pclk);
		pair_valid <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : pairs
	task t_access;
		apb(0, 8'h10, 0); chk(rd, 32'h0); chk(err, 0);
		apb(1, 8'h10, 32'hffff); chk(err, 1);
		apb(0, 8'h30, 0); chk(err, 1);
		apb(0, 8'h24, 0); chk(rd, 32'h0);
	endtask : t_access
	task t_signal;
		pin <= 1'b0; repeat (5) @(posedge pclk);
		apb(0, 8'h10, 0); chk(rd, 32'h400);
		pin <= 1'b1; repeat (5) @(posedge pclk);
		apb(0, 8'h10, 0); chk(rd[10], 0);
	endtask : t_signal
	// walk of line states: class, pairs, expected current and previous
	task t_states;
		logic [2:0] cls [11] = '{4, 5, 5, 6, 1, 0, 3, 3, 1, 2, 4};
		int cnt [11] = '{8, 7, 1, 8, 8, 8, 2, 6, 8, 8, 7};
		logic [2:0] cur [11] = '{4, 4, 5, 6, 1, 0, 3, 7, 1, 1, 1};
		logic [1:0] prv [11] = '{0, 0, 0, 1, 2, 2, 2, 2, 3, 3, 3};
		for (int i = 0; i < 11; i++) begin
			pairs(cls[i], cnt[i]);
			apb(0, 8'h10, 0);
			chk(rd, {22'h0, prv[i], cur[i], 5'h0});
			apb(0, 8'h10, 0);
			chk(rd, {22'h0, prv[i], cur[i], 5'h0});
		end
	endtask : t_states
	task t_irq;
		apb(1, 8'h24, 32'h1); apb(0, 8'h24, 0); chk(rd, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 1);
		apb(1, 8'h20, 32'hf); repeat (2) @(posedge pclk);
		chk(irq, 0);
		pairs(3'h6, 8); repeat (2) @(posedge pclk);
		chk(irq, 1);
		apb(0, 8'h20, 0); chk(rd[0], 1);
		apb(1, 8'h24, 32'h0); repeat (2) @(posedge pclk);
		chk(irq, 0);
	endtask : t_irq
	task results;
		$display("checks=%0d failures=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_access;
		t_signal;
		t_states;
		t_irq;
		results;
	end
	// hang guard, far beyond the length of the sequence
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		results;
	end
endmodule : line_state_status_reg_tb
`default_nettype wire
